/* File: rtl/squib_loop_diag_config.sv */
// configuration bank for squib loop and dc sensor diagnostics
//
// Function
// R01: bit 15 selects low or high field layout
// R02: magnitude bit picks 40 mA or 8 mA
// R03: pull-down off on used channels, or all
// R04: source field off, current or bypass
// R05: code 11 adds diff amplifier on partner
// R06: sink bit enables 50 mA sink
// R07: monitor off or on selected feed pin
// R08: monitor return pin, pull-down off or kept
// R09: host keeps sink, source off with monitor 11
// R10: resistance channel codes 0-7, others none
// R11: leakage channel codes 0-7 for tests
// R12: resets zero all fields, else SPI write
// R13: high mode three-bit diagnostic select
// R14: squib pin bit picks return or feed
// R15: high mode loop channel 0-7, others none
// R16: high mode bits 14:8 ignored, read zero
// R17: inhibit polarity selects inside or outside
// R18: sensor pull-down off on measured or all
// R19: switch output enable resets off
// R20: sensor channel codes 0-8, others none
`timescale 1ns/10ps
`default_nettype none
module squib_loop_diag_config
    import loop_diag_pkg::*;
(
    // clock and resets
    input  wire logic                                clk,
    input  wire logic                                rst_b,
    input  wire logic                                watchdog_machine_reset,
    input  wire logic                                safing_machine_reset,
    // decoded serial register access
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    input  wire logic [7:0]                          reg_id,
    input  wire logic [loop_diag_pkg::REG_W-1:0]     reg_wdata,
    output logic      [loop_diag_pkg::REG_W-1:0]     reg_rdata,
    output logic                                     reg_hit,
    // low level loop controls
    output logic                                     test_depth_select,
    output logic                                     source_magnitude_8ma,
    output logic      [loop_diag_pkg::CHAN_N-1:0]    source_on,
    output logic      [loop_diag_pkg::CHAN_N-1:0]    bypass_on,
    output logic      [loop_diag_pkg::CHAN_N-1:0]    resistance_diff_amplifier,
    output logic      [loop_diag_pkg::CHAN_N-1:0]    sink_on,
    output logic      [loop_diag_pkg::CHAN_N-1:0]    monitor_feed_pin,
    output logic      [loop_diag_pkg::CHAN_N-1:0]    monitor_return_pin,
    output logic      [loop_diag_pkg::CHAN_N-1:0]    loop_pulldown_off,
    output logic      [loop_diag_pkg::CHAN_N-1:0]    resistance_channel,
    output logic      [loop_diag_pkg::CHAN_N-1:0]    leakage_channel,
    // high level loop selections
    output logic      [2:0]                          auto_diagnostic_select,
    output logic                                     squib_pin_select,
    output logic      [loop_diag_pkg::CHAN_N-1:0]    auto_loop_channel,
    // dc sensor controls
    output logic                                     passenger_inhibit_polarity,
    output logic                                     sensor_pulldown_disable,
    output logic                                     sensor_switch_output_enable,
    output logic      [loop_diag_pkg::SENS_N-1:0]    sensor_channel
);

    // ***********************************************************
    // register storage
    // ***********************************************************
    logic [REG_W-1:0] loop_diag_config_q;
    logic [REG_W-1:0] loop_diag_config_d;
    logic [REG_W-1:0] dc_sensor_diag_config_q;
    logic [REG_W-1:0] dc_sensor_diag_config_d;
    logic [REG_W-1:0] rdata_q;
    logic [REG_W-1:0] rdata_d;
    logic             machine_reset;
    logic             loop_sel;
    logic             dcs_sel;


    // the watchdog and safing machines share this clock,
    // so their resets need no synchroniser

    // they are levels: the bank stays clear while either is high

    // state machine resets act like power-on on every field
    assign machine_reset = watchdog_machine_reset | safing_machine_reset;
    assign loop_sel      = (reg_id == LOOP_DIAG_CONFIG_ID);
    assign dcs_sel       = (reg_id == DC_SENSOR_DIAG_CONFIG_ID);
    // handshake output: tells the frame logic the identifier belongs here
    assign reg_hit       = loop_sel | dcs_sel;


    // a write replaces every field at once; there is no
    // read-modify-write, so the host sends the whole word

    // write masking for the loop register; the layout follows the
    // depth bit being written, not the one already stored
    always_comb begin
        loop_diag_config_d = '0;
        // bits above the depth bit never store
        loop_diag_config_d[TEST_DEPTH_BIT:0] = reg_wdata[TEST_DEPTH_BIT:0];

        if (reg_wdata[TEST_DEPTH_BIT]) begin
            // high layout drops the low level fields so they cannot
            // linger as live controls while automation runs
            loop_diag_config_d[LOW_FIELDS_MSB:MON_FIELD_LSB] = '0; // R16
        end
    end


    // bits 5:4 and 19:9 are dropped here,
    // so a later read shows zero there

    // only the documented sensor bits are kept; the rest read zero
    always_comb begin
        dc_sensor_diag_config_d                 = '0;
        dc_sensor_diag_config_d[INH_POL_BIT]    = reg_wdata[INH_POL_BIT];
        dc_sensor_diag_config_d[SENS_PD_BIT]    = reg_wdata[SENS_PD_BIT];
        dc_sensor_diag_config_d[SW_OE_BIT]      = reg_wdata[SW_OE_BIT];
        dc_sensor_diag_config_d[SENS_CHAN_LSB +: 4] =
            reg_wdata[SENS_CHAN_LSB +: 4];
    end


    // a machine reset in the same cycle as a write wins;
    // the host must repeat a write that raced a reset

    // loop register: reset by any of the three resets, else writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            loop_diag_config_q <= REG_RESET; // R12
        end else if (machine_reset) begin
            loop_diag_config_q <= REG_RESET; // R12
        end else if (reg_wr && loop_sel) begin
            loop_diag_config_q <= loop_diag_config_d; // R12
        end
    end


    // the switch output must come up off after any reset,
    // so power-on alone is not enough here

    // sensor register: same reset set as the loop register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dc_sensor_diag_config_q <= REG_RESET; // R19
        end else if (machine_reset) begin
            dc_sensor_diag_config_q <= REG_RESET; // R19
        end else if (reg_wr && dcs_sel) begin
            dc_sensor_diag_config_q <= dc_sensor_diag_config_d; // R19
        end
    end

    // ***********************************************************
    // read back
    // ***********************************************************


    // other identifiers belong to other banks; zero keeps
    // this bank from fighting them on a shared read path

    // unknown identifiers answer zero rather than holding old data
    always_comb begin
        rdata_d = '0;
        if (loop_sel) begin
            rdata_d = loop_diag_config_q; // R16
        end else if (dcs_sel) begin
            rdata_d = dc_sensor_diag_config_q;
        end
    end


    // the word is held in a flip-flop so the frame logic can
    // shift it out while reg_id moves on

    // machine resets leave it alone; a stale word is harmless

    // read data is captured on the read strobe and held until the next
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= REG_RESET;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end
    end

    // data output straight from a flip-flop
    assign reg_rdata = rdata_q;


    // ***********************************************************
    // field views
    // ***********************************************************

    // named slices keep the decode below readable;
    // both layouts share the low eight bits

    logic       high_mode;
    logic [1:0] src_field;
    logic [1:0] mon_field;
    logic [3:0] res_code;
    logic [3:0] leak_code;
    logic [3:0] auto_code;
    logic [3:0] sens_code;
    logic       sink_bit;
    logic       loop_pd_bit;

    assign high_mode   = loop_diag_config_q[TEST_DEPTH_BIT]; // R01
    assign src_field   = loop_diag_config_q[SRC_FIELD_LSB +: 2];
    assign mon_field   = loop_diag_config_q[MON_FIELD_LSB +: 2];
    assign res_code    = loop_diag_config_q[RES_CHAN_LSB +: 4];
    assign leak_code   = loop_diag_config_q[LEAK_CHAN_LSB +: 4];
    assign auto_code   = loop_diag_config_q[AUTO_CHAN_LSB +: 4];
    assign sens_code   = dc_sensor_diag_config_q[SENS_CHAN_LSB +: 4];
    assign sink_bit    = loop_diag_config_q[SINK_BIT];
    assign loop_pd_bit = loop_diag_config_q[LOOP_PD_BIT];

    // ***********************************************************
    // per channel decode
    // ***********************************************************
    // every output below comes straight from the stored fields, so a
    // control changes the cycle after the write lands

    logic [CHAN_N-1:0] res_hot;
    logic [CHAN_N-1:0] leak_hot;
    logic [CHAN_N-1:0] pair_hot;
    logic              src_active;
    logic              mon_to_ret;
    logic              mon_pd_off;

    // codes 8 and above are taken as no channel in both layouts
    assign src_active = !high_mode && (src_field != SRC_OFF);
    assign mon_to_ret = (mon_field == MON_RET_PDX) ||
                        (mon_field == MON_RET_PD);
    // monitor code 11 keeps the pull-down running on purpose
    assign mon_pd_off = (mon_field == MON_FEED) ||
                        (mon_field == MON_RET_PDX); // R08


    // channels pair as 0-1, 2-3, 4-5 and 6-7,
    // so the partner is the code with bit 0 flipped

    // the host keeps sink and source off with monitor
    // code 11; nothing here blocks a bad mix

    genvar ch;
    generate
        for (ch = 0; ch < CHAN_N; ch++) begin : g_chan
            localparam logic [3:0] CODE = 4'(ch);
            localparam logic [3:0] PART = 4'(ch ^ 1);


            // channel hits; only codes 0..7 can match a channel
            assign res_hot[ch]  = !high_mode && (res_code == CODE); // R10
            assign leak_hot[ch] = !high_mode && (leak_code == CODE); // R11
            // partner channel of the measured pair
            assign pair_hot[ch] = !high_mode && (res_code == PART);

            assign source_on[ch] = res_hot[ch] &&
                ((src_field == SRC_ON) || (src_field == SRC_ON_DIFF)); // R04
            assign bypass_on[ch] = res_hot[ch] &&
                (src_field == SRC_BYPASS); // R04
            // amplifier goes to the other squib of the selected pair
            assign resistance_diff_amplifier[ch] = pair_hot[ch] &&
                (src_field == SRC_ON_DIFF); // R05
            // sink current itself is clamped to 50 mA in the driver
            assign sink_on[ch] = res_hot[ch] && sink_bit; // R06
            assign monitor_feed_pin[ch] = leak_hot[ch] &&
                (mon_field == MON_FEED); // R07
            assign monitor_return_pin[ch] = leak_hot[ch] && mon_to_ret; // R08


            // bypass counts as a source here, since it
            // also drives current into the loop

            // pull-down released on any channel a source, sink or monitor
            // code 01 or 10 touches, unless the blanket bit drops them all
            assign loop_pulldown_off[ch] = !high_mode && (loop_pd_bit ||
                (res_hot[ch] && (src_active || sink_bit)) ||
                (leak_hot[ch] && mon_pd_off)); // R03


            // mux selects follow the stored codes
            assign resistance_channel[ch] = res_hot[ch]; // R10
            assign leakage_channel[ch]    = leak_hot[ch]; // R11
            assign auto_loop_channel[ch]  = high_mode &&
                (auto_code == CODE); // R15
        end
    endgenerate


    // codes 9 to 15 light no sensor channel

    // sensor channel select, nine channels
    genvar sc;
    generate
        for (sc = 0; sc < SENS_N; sc++) begin : g_sens
            assign sensor_channel[sc] = (sens_code == 4'(sc)); // R20
        end
    endgenerate

    // ***********************************************************
    // mode wide controls
    // ***********************************************************


    // the diagnostic machines read the mode bit directly
    assign test_depth_select = high_mode; // R01

    // magnitude only means something while a source is on
    assign source_magnitude_8ma = !high_mode &&
        loop_diag_config_q[SRC_MAG_BIT]; // R02

    // high level fields share bits with the low layout, so gate them
    assign auto_diagnostic_select = high_mode ?
        loop_diag_config_q[AUTO_DIAG_LSB +: 3] : DIAG_NONE; // R13
    assign squib_pin_select = high_mode &&
        loop_diag_config_q[SQUIB_PIN_BIT]; // R14


    // the sensor bank has one layout, so no gating

    // sensor side controls straight from storage
    assign passenger_inhibit_polarity =
        dc_sensor_diag_config_q[INH_POL_BIT]; // R17
    assign sensor_pulldown_disable =
        dc_sensor_diag_config_q[SENS_PD_BIT]; // R18
    assign sensor_switch_output_enable =
        dc_sensor_diag_config_q[SW_OE_BIT]; // R19

    // limitation: these are requests only; the analog side
    // enforces current limits and timing

    // the result registers live elsewhere

endmodule : squib_loop_diag_config
`default_nettype wire

/* File: rtl/loop_diag_pkg.sv */
// constants for the squib loop and dc sensor diagnostic configuration bank
`default_nettype none
package loop_diag_pkg;

    // ***********************************************************
    // register identifiers as seen in the serial frame
    // ***********************************************************
    localparam logic [7:0] LOOP_DIAG_CONFIG_ID      = 8'h38;
    localparam logic [7:0] DC_SENSOR_DIAG_CONFIG_ID = 8'h39;

    localparam int REG_W   = 20;
    localparam int CHAN_N  = 8;
    localparam int SENS_N  = 9;

    // ***********************************************************
    // loop_diag_config field positions
    // ***********************************************************
    localparam int TEST_DEPTH_BIT   = 15;
    localparam int SRC_MAG_BIT      = 14;
    localparam int LOOP_PD_BIT      = 13;
    localparam int SRC_FIELD_LSB    = 11;
    localparam int SINK_BIT         = 10;
    localparam int MON_FIELD_LSB    = 8;
    localparam int RES_CHAN_LSB     = 4;
    localparam int LEAK_CHAN_LSB    = 0;
    localparam int AUTO_DIAG_LSB    = 5;
    localparam int SQUIB_PIN_BIT    = 4;
    localparam int AUTO_CHAN_LSB    = 0;
    localparam int LOW_FIELDS_MSB   = 14;

    // ***********************************************************
    // dc_sensor_diag_config field positions
    // ***********************************************************
    localparam int INH_POL_BIT      = 8;
    localparam int SENS_PD_BIT      = 7;
    localparam int SW_OE_BIT        = 6;
    localparam int SENS_CHAN_LSB    = 0;

    // reset value of both registers
    localparam logic [REG_W-1:0] REG_RESET = 20'h00000;

    // ***********************************************************
    // field encodings
    // ***********************************************************
    localparam logic [1:0] SRC_OFF      = 2'h0;
    localparam logic [1:0] SRC_ON       = 2'h1;
    localparam logic [1:0] SRC_BYPASS   = 2'h2;
    localparam logic [1:0] SRC_ON_DIFF  = 2'h3;
    localparam logic [1:0] MON_OFF      = 2'h0;
    localparam logic [1:0] MON_FEED     = 2'h1;
    localparam logic [1:0] MON_RET_PDX  = 2'h2;
    localparam logic [1:0] MON_RET_PD   = 2'h3;

    // high level diagnostic selections
    typedef enum logic [2:0] {
        DIAG_NONE, DIAG_MON_CHECK, DIAG_LEAK_CHECK, DIAG_SHORT_LOOPS,
        DIAG_RESERVE_ESR, DIAG_RES_RANGE, DIAG_RES_MEAS, DIAG_FET_TEST
    } auto_diag_e;

endpackage : loop_diag_pkg
`default_nettype wire

/* File: verif/loop_diag_chk.sv */
// concurrent checks on the loop and dc sensor configuration bank ports
`timescale 1ns/10ps
`default_nettype none
module loop_diag_chk
    import loop_diag_pkg::*;
(
    // clock and resets
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        watchdog_machine_reset,
    input wire logic        safing_machine_reset,
    // register access
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_id,
    input wire logic [19:0] reg_wdata,
    input wire logic [19:0] reg_rdata,
    input wire logic        reg_hit,
    // decoded controls
    input wire logic        test_depth_select,
    input wire logic [7:0]  source_on,
    input wire logic [7:0]  bypass_on,
    input wire logic [7:0]  resistance_diff_amplifier,
    input wire logic [7:0]  sink_on,
    input wire logic [7:0]  monitor_feed_pin,
    input wire logic [7:0]  monitor_return_pin,
    input wire logic [7:0]  loop_pulldown_off,
    input wire logic [7:0]  resistance_channel,
    input wire logic [7:0]  leakage_channel,
    input wire logic [7:0]  auto_loop_channel,
    input wire logic [8:0]  sensor_channel
);
    // ***********************************************************
    // helpers
    // ***********************************************************
    logic       mres;
    logic [7:0] pair_of_diff;
    // either machine reset clears both registers
    assign mres = watchdog_machine_reset | safing_machine_reset;
    // the amplifier sits on the other channel of the source's pair
    assign pair_of_diff = {resistance_diff_amplifier[6],
        resistance_diff_amplifier[7], resistance_diff_amplifier[4],
        resistance_diff_amplifier[5], resistance_diff_amplifier[2],
        resistance_diff_amplifier[3], resistance_diff_amplifier[0],
        resistance_diff_amplifier[1]};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_mres_clear; mres |=> !test_depth_select &&
        sensor_channel == 9'h001 && resistance_channel == 8'h01; endproperty
    a_mres_clear: assert property (p_mres_clear)
        else $error("machine reset left a field set");
    property p_hold; !reg_wr && !mres |=> $stable({test_depth_select,
        source_on, sink_on, leakage_channel, sensor_channel}); endproperty
    a_hold: assert property (p_hold)
        else $error("controls changed without a write");
    property p_depth_wr; reg_wr && reg_id == 8'h38 && !mres |=>
        test_depth_select == $past(reg_wdata[15]); endproperty
    a_depth_wr: assert property (p_depth_wr)
        else $error("depth bit not taken from write");
    property p_high_quiet; test_depth_select |-> (source_on | bypass_on |
        sink_on | monitor_feed_pin | monitor_return_pin |
        resistance_channel | leakage_channel) == 8'h00; endproperty
    a_high_quiet: assert property (p_high_quiet)
        else $error("low level control active in high mode");
    property p_low_quiet; !test_depth_select |-> auto_loop_channel == 8'h00;
    endproperty
    a_low_quiet: assert property (p_low_quiet)
        else $error("auto channel active in low mode");
    property p_diff; |resistance_diff_amplifier |-> source_on == pair_of_diff;
    endproperty
    a_diff: assert property (p_diff)
        else $error("amplifier not on partner channel");
    property p_bypass; |bypass_on |-> bypass_on == resistance_channel &&
        source_on == 8'h00; endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass on wrong channel");
    property p_sink; |sink_on |-> sink_on == resistance_channel; endproperty
    a_sink: assert property (p_sink)
        else $error("sink on wrong channel");
    property p_feed; |monitor_feed_pin |-> monitor_feed_pin == leakage_channel
        && monitor_return_pin == 8'h00; endproperty
    a_feed: assert property (p_feed)
        else $error("monitor feed connection wrong");
    property p_ret; |monitor_return_pin |->
        monitor_return_pin == leakage_channel; endproperty
    a_ret: assert property (p_ret)
        else $error("monitor return connection wrong");
    property p_pulldown; !test_depth_select |-> ((source_on | bypass_on |
        sink_on | monitor_feed_pin) & ~loop_pulldown_off) == 8'h00; endproperty
    a_pulldown: assert property (p_pulldown)
        else $error("pull-down left on a used channel");
    property p_read; reg_rd |=> reg_rdata[19:16] == 4'h0 &&
        ($past(reg_hit) || reg_rdata == 20'h00000); endproperty
    a_read: assert property (p_read)
        else $error("read data padding wrong");
endmodule : loop_diag_chk
bind squib_loop_diag_config loop_diag_chk u_chk (.clk, .rst_b,
    .watchdog_machine_reset, .safing_machine_reset, .reg_wr, .reg_rd, .reg_id,
    .reg_wdata, .reg_rdata, .reg_hit, .test_depth_select, .source_on,
    .bypass_on, .resistance_diff_amplifier, .sink_on, .monitor_feed_pin,
    .monitor_return_pin, .loop_pulldown_off, .resistance_channel,
    .leakage_channel, .auto_loop_channel, .sensor_channel);
`default_nettype wire

/* File: verif/host_model.sv */
// host model issuing register accesses to the configuration bank
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // clock
    input  wire logic        clk,
    // register access
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [7:0]       reg_id,
    output logic [19:0]      reg_wdata,
    input  wire logic [19:0] reg_rdata
);
    // bus idle at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_id = 8'h00;
        reg_wdata = 20'h00000;
    end
    // one-cycle write; released lines show the inverse, never stale values
    task automatic write_reg(input logic [7:0] id, input logic [19:0] d);
        if (id == 8'h38 && !d[15] && d[9:8] == 2'h3) d[12:10] = 3'h0;
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_id <= id;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_id <= ~id;
        reg_wdata <= ~d;
        #1;
    endtask : write_reg
    // one-cycle read; data is registered at the edge closing the strobe
    task automatic read_reg(input logic [7:0] id, output logic [19:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_id <= id;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_id <= ~id;
        #1;
        d = reg_rdata;
    endtask : read_reg
endmodule : host_model
`default_nettype wire

/* File: verif/tb.sv */
// self-checking testbench for the squib loop diagnostic configuration bank
`timescale 1ns/10ps
`default_nettype none
module tb;
    import loop_diag_pkg::*;
    logic clk, rst_b, watchdog_machine_reset, safing_machine_reset;
    logic reg_wr, reg_rd, reg_hit, test_depth_select, source_magnitude_8ma;
    logic squib_pin_select, passenger_inhibit_polarity;
    logic sensor_pulldown_disable, sensor_switch_output_enable;
    logic [7:0] reg_id, source_on, bypass_on, resistance_diff_amplifier;
    logic [7:0] sink_on, monitor_feed_pin, monitor_return_pin, pd;
    logic [7:0] loop_pulldown_off, resistance_channel, leakage_channel;
    logic [7:0] auto_loop_channel;
    logic [19:0] reg_wdata, reg_rdata, rd, w;
    logic [2:0] auto_diagnostic_select;
    logic [8:0] sensor_channel;
    int n_mismatch, compares, cyc, se;
    squib_loop_diag_config DUT (
        .clk, .rst_b, .watchdog_machine_reset, .safing_machine_reset,
        .reg_wr, .reg_rd, .reg_id, .reg_wdata, .reg_rdata, .reg_hit,
        .test_depth_select, .source_magnitude_8ma, .source_on, .bypass_on,
        .resistance_diff_amplifier, .sink_on, .monitor_feed_pin,
        .monitor_return_pin, .loop_pulldown_off, .resistance_channel,
        .leakage_channel, .auto_diagnostic_select, .squib_pin_select,
        .auto_loop_channel, .passenger_inhibit_polarity,
        .sensor_pulldown_disable, .sensor_switch_output_enable, .sensor_channel
    );
    host_model host (.clk, .reg_wr, .reg_rd, .reg_id, .reg_wdata, .reg_rdata);
    // one-hot of a channel code, zero past the last channel
    function automatic logic [8:0] hot(input int c, input int n);
        hot = (c < n) ? 9'h001 << c : 9'h000;
    endfunction : hot
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task complete_run;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // cut a hang short well beyond the few hundred cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            complete_run;
        end
    end
    initial begin
        rst_b = 1'b0;
        watchdog_machine_reset = 1'b0;
        safing_machine_reset = 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        host.read_reg(8'h38, rd);
        check(rd, 20'h00000);
        host.read_reg(8'h39, rd);
        check({rd, sensor_channel}, {20'h00000, 9'h001});
        $display("reset test done");
        // source, sink and monitor codes on channel 6 and channel 1
        for (int s = 0; s < 4; s++) begin
            for (int m = 0; m < 4; m++) begin
                w = {5'h1e, s[0], 1'(s + m == 5), s[1:0], 1'(m == 0), m[1:0],
                     8'h61};
                se = (m == 3) ? 0 : s;
                host.write_reg(8'h38, w);
                check({source_on, bypass_on, resistance_diff_amplifier},
                    {(se % 2) ? 8'h40 : 8'h00, (se == 2) ? 8'h40 : 8'h00,
                     (se == 3) ? 8'h80 : 8'h00});
                check({sink_on, monitor_feed_pin, monitor_return_pin},
                    {(m == 0) ? 8'h40 : 8'h00, (m == 1) ? 8'h02 : 8'h00,
                     (m > 1) ? 8'h02 : 8'h00});
                check(source_magnitude_8ma, s[0]);
                pd = ((se != 0 || m == 0) ? 8'h40 : 8'h00) |
                     ((m == 1 || m == 2) ? 8'h02 : 8'h00);
                check(loop_pulldown_off, (s + m == 5) ? 8'hff : pd);
            end
        end
        $display("source and monitor test done");
        // every channel code in both layouts and the sensor register
        for (int c = 0; c < 16; c++) begin
            host.write_reg(8'h38, 20'(c * 17));
            check({1'b0, resistance_channel, 1'b0, leakage_channel},
                  {hot(c, 8), hot(c, 8)});
            w = {12'hfff, c[2:0], c[0], c[3:0]};
            host.write_reg(8'h38, w);
            host.read_reg(8'h38, rd);
            check(rd, {12'h080, w[7:0]});
            check({auto_diagnostic_select, squib_pin_select, auto_loop_channel,
                   resistance_channel},
                  {c[2:0], c[0], 8'(hot(c, 8)), 8'h00});
            w = {11'h7ff, c[0], c[1], c[2], 2'h3, c[3:0]};
            host.write_reg(8'h39, w);
            host.read_reg(8'h39, rd);
            check(rd, w & 20'h001cf);
            check({passenger_inhibit_polarity, sensor_pulldown_disable,
                   sensor_switch_output_enable, sensor_channel},
                  {c[0], c[1], c[2], hot(c, 9)});
        end
        $display("channel code test done");
        host.write_reg(8'h3a, 20'hfffff);
        host.read_reg(8'h3a, rd);
        check(rd, 20'h00000);
        host.read_reg(8'h39, rd);
        check(rd, 20'h001cf);
        @(posedge clk) watchdog_machine_reset <= 1'b1;
        @(posedge clk) watchdog_machine_reset <= 1'b0;
        host.read_reg(8'h39, rd);
        check({rd, sensor_switch_output_enable}, 21'h000000);
        @(posedge clk) safing_machine_reset <= 1'b1;
        host.write_reg(8'h38, 20'h05925);
        @(posedge clk) safing_machine_reset <= 1'b0;
        host.read_reg(8'h38, rd);
        check(rd, 20'h00000);
        $display("machine reset test done");
        complete_run;
    end
endmodule : tb
`default_nettype wire
